// ===== fifo_ctl.sv
/*
 * Controller driving a strobed fall-through FIFO through its pins, with
 * command and status registers on an Avalon-MM slave.
 * Assumes the FIFO pins are asynchronous to i_clk; the tristate data
 * output is resolved outside, sampled here only while output enable is on.
 */
// Behaviour
// - Controller pulses master reset after power-up before using the buffer.
// - Controller holds master reset low at least the minimum pulse width.
// - Narrow words by grounding unused inputs, ignoring matching outputs.
// - Wider words share strobes and AND matching flags of all devices.
`timescale 1ns/100ps
`default_nettype none
`include "fifo_ctl_map.svh"
module fifo_ctl (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire logic [3:0]            i_avs_address,
	input  wire logic                  i_avs_read,
	input  wire logic                  i_avs_write,
	input  wire logic [31:0]           i_avs_writedata,
	output logic      [31:0]           o_avs_readdata,
	output logic                       o_avs_waitrequest,
	output logic                       o_master_reset_n,
	output logic                       o_shift_in,
	output logic                       o_shift_out,
	output logic                       o_output_enable_n,
	output logic      [`WORD_BITS-1:0] o_data_in,
	input  wire logic [`WORD_BITS-1:0] i_data_out,
	input  wire logic                  i_input_ready,
	input  wire logic                  i_output_ready,
	input  wire logic                  i_occupancy_flag,
	input  wire logic                  i_upper_half_flag
);
	/**********************************************************************
	 * Pin synchronisers
	 **********************************************************************/
	logic [`WORD_BITS+3:0] sync_bus;
	fifo_ctl_pkg::fifo_flags_t flags;
	logic [`WORD_BITS-1:0] data_sync;

	pin_sync #(.WIDTH(`WORD_BITS + 4)) u_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_async ({i_input_ready, i_output_ready, i_occupancy_flag,
			i_upper_half_flag, i_data_out}),
		.o_sync  (sync_bus)
	);
	// One device wide, so the ANDed composite is its own flag set
	assign flags     = sync_bus[`WORD_BITS+3:`WORD_BITS];
	assign data_sync = sync_bus[`WORD_BITS-1:0];

	/**********************************************************************
	 * Pin sequencer and bus slave
	 **********************************************************************/
	fifo_ctl_pkg::ctl_state_t state, next_state;
	fifo_ctl_pkg::fifo_drive_t drive, next_drive;
	logic [`TIMER_BITS-1:0] timer, next_timer;
	logic [`WORD_BITS-1:0]  rdata, next_rdata;
	logic                   booted, next_booted;
	logic                   refused, next_refused;
	logic [31:0]            readdata, next_readdata;
	logic                   waitreq, next_waitreq;
	logic                   busy;
	logic                   empty;
	logic                   full;
	logic                   wr_cmd;

	assign busy   = (state != fifo_ctl_pkg::ST_IDLE) || !booted;
	// Flag pair decode: both low empty, upper-half alone full
	assign empty  = !flags.occupancy_flag && !flags.upper_half_flag;
	assign full   = !flags.occupancy_flag && flags.upper_half_flag;
	assign wr_cmd = i_avs_write && waitreq
		&& i_avs_address == `CTL_REG_CMD;

	always_comb begin
		next_state    = state;
		next_drive    = drive;
		next_timer    = (timer != '0) ? timer - 1'b1 : timer;
		next_rdata    = rdata;
		next_booted   = booted;
		next_refused  = refused;
		next_readdata = readdata;
		// Every access is answered one cycle late so reads see fresh state
		next_waitreq  = !((i_avs_read || i_avs_write) && waitreq);
		if (i_avs_read && waitreq) begin
			case (i_avs_address)
				`CTL_REG_WDATA:  next_readdata = 32'(drive.data_in);
				`CTL_REG_STATUS: next_readdata = 32'({refused, full, empty,
					flags.upper_half_flag, flags.occupancy_flag,
					flags.output_ready, flags.input_ready, busy});
				`CTL_REG_RDATA:  next_readdata = 32'(rdata);
				default:         next_readdata = 32'h0000_0000;
			endcase
		end
		if (i_avs_write && waitreq && i_avs_address == `CTL_REG_WDATA
				&& state == fifo_ctl_pkg::ST_IDLE)
			next_drive.data_in = i_avs_writedata[`WORD_BITS-1:0];
		if (wr_cmd)
			next_drive.output_enable_n = !i_avs_writedata[`CMD_BIT_OE];
		case (state)
			fifo_ctl_pkg::ST_IDLE: begin
				if (!booted || (wr_cmd && i_avs_writedata[`CMD_BIT_RESET])) begin
					next_drive.master_reset_n = 1'b0;
					next_timer = `TIMER_BITS'(`RESET_CYCLES);
					next_state = fifo_ctl_pkg::ST_RESET;
				end else if (wr_cmd && i_avs_writedata[`CMD_BIT_SHIFT_IN]) begin
					// Strobe only when input-ready; a full FIFO would drop it
					if (flags.input_ready && !full) begin
						next_drive.shift_in = 1'b1;
						next_timer = `TIMER_BITS'(`STROBE_CYCLES);
						next_state = fifo_ctl_pkg::ST_SI_HIGH;
						next_refused = 1'b0;
					end else
						next_refused = 1'b1;
				end else if (wr_cmd && i_avs_writedata[`CMD_BIT_SHIFT_OUT]) begin
					if (flags.output_ready && !empty) begin
						next_drive.shift_out = 1'b1;
						next_timer = `TIMER_BITS'(`STROBE_CYCLES);
						next_state = fifo_ctl_pkg::ST_SO_HIGH;
						next_refused = 1'b0;
					end else
						next_refused = 1'b1;
				end
			end
			fifo_ctl_pkg::ST_RESET: begin
				if (timer == '0) begin
					next_drive.master_reset_n = 1'b1;
					next_booted = 1'b1;
					next_timer = `TIMER_BITS'(`SETTLE_CYCLES);
					next_state = fifo_ctl_pkg::ST_SI_LOW;
				end
			end
			fifo_ctl_pkg::ST_SI_HIGH: begin
				if (timer == '0) begin
					next_drive.shift_in = 1'b0;
					next_timer = `TIMER_BITS'(`SETTLE_CYCLES);
					next_state = fifo_ctl_pkg::ST_SI_LOW;
				end
			end
			fifo_ctl_pkg::ST_SI_LOW: begin
				// Settle time lets flags reach the synchronisers
				if (timer == '0)
					next_state = fifo_ctl_pkg::ST_IDLE;
			end
			fifo_ctl_pkg::ST_SO_HIGH: begin
				if (timer == '0) begin
					next_drive.shift_out = 1'b0;
					next_timer = `TIMER_BITS'(`SETTLE_CYCLES);
					next_state = fifo_ctl_pkg::ST_SO_LOW;
				end
			end
			fifo_ctl_pkg::ST_SO_LOW: begin
				if (timer == '0) begin
					// Word shown before this shift-out was the one taken
					next_state = fifo_ctl_pkg::ST_IDLE;
				end
			end
			default: next_state = fifo_ctl_pkg::ST_IDLE;
		endcase
		// Capture head word before strobing it away, in write order
		if (state == fifo_ctl_pkg::ST_IDLE && next_state
				== fifo_ctl_pkg::ST_SO_HIGH && !drive.output_enable_n)
			next_rdata = data_sync;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state    <= fifo_ctl_pkg::ST_IDLE;
			drive    <= {1'b1, 1'b0, 1'b0, 1'b1, `DATA_RESET};
			timer    <= '0;
			rdata    <= `DATA_RESET;
			booted   <= 1'b0;
			refused  <= 1'b0;
			readdata <= 32'h0000_0000;
			waitreq  <= 1'b1;
		end else begin
			state    <= next_state;
			drive    <= next_drive;
			timer    <= next_timer;
			rdata    <= next_rdata;
			booted   <= next_booted;
			refused  <= next_refused;
			readdata <= next_readdata;
			waitreq  <= next_waitreq;
		end
	end

	assign o_master_reset_n  = drive.master_reset_n;
	assign o_shift_in        = drive.shift_in;
	assign o_shift_out       = drive.shift_out;
	assign o_output_enable_n = drive.output_enable_n;
	assign o_data_in         = drive.data_in;
	assign o_avs_readdata    = readdata;
	assign o_avs_waitrequest = waitreq;
endmodule // fifo_ctl
`default_nettype wire

// ===== fifo_ctl_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * strobed FIFO controller.
 * Assumes a 100 MHz clock and word-aligned Avalon-MM byte addresses.
 */
`ifndef FIFO_CTL_MAP_SVH
`define FIFO_CTL_MAP_SVH

`define CTL_REG_CMD       4'h0
`define CTL_REG_WDATA     4'h4
`define CTL_REG_STATUS    4'h8
`define CTL_REG_RDATA     4'hC

`define CMD_BIT_RESET     0
`define CMD_BIT_SHIFT_IN  1
`define CMD_BIT_SHIFT_OUT 2
`define CMD_BIT_OE        3

`define ST_BIT_BUSY       0
`define ST_BIT_IN_READY   1
`define ST_BIT_OUT_READY  2
`define ST_BIT_OCC        3
`define ST_BIT_UPPER      4
`define ST_BIT_EMPTY      5
`define ST_BIT_FULL       6

`define WORD_BITS         9
`define DATA_RESET        9'h000

`define RESET_WIDTH_NS    31
`define STROBE_WIDTH_NS   40
`define SETTLE_NS         40
`define CLK_PERIOD_NS     10
`define RESET_CYCLES  ((`RESET_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYCLES ((`STROBE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_BITS        4

`endif

// ===== fifo_ctl_pkg.sv
/*
 * Types of the strobed FIFO controller.
 * Assumes fifo_ctl_map.svh for widths.
 */
`include "fifo_ctl_map.svh"
package fifo_ctl_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_RESET, ST_SI_HIGH, ST_SI_LOW, ST_SO_HIGH, ST_SO_LOW
	} ctl_state_t;

	typedef struct packed {
		logic input_ready;
		logic output_ready;
		logic occupancy_flag;
		logic upper_half_flag;
	} fifo_flags_t;

	typedef struct packed {
		logic                    master_reset_n;
		logic                    shift_in;
		logic                    shift_out;
		logic                    output_enable_n;
		logic [`WORD_BITS-1:0]   data_in;
	} fifo_drive_t;
endpackage

// ===== pin_sync.sv
/*
 * Two-flop synchroniser for a bundle of asynchronous pin inputs.
 * Assumes its inputs may change at any time relative to i_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 13
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	always_comb begin
		next_meta = i_async;
		next_sync = meta;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta   <= '0;
			o_sync <= '0;
		end else begin
			meta   <= next_meta;
			o_sync <= next_sync;
		end
	end
endmodule // pin_sync
`default_nettype wire

// ===== fifo_ctl_chk.sv
/* Pin-side assertions for the strobed FIFO controller.
   Assumes it is bound into fifo_ctl and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
`include "fifo_ctl_map.svh"
module fifo_ctl_chk (
	input wire logic                  i_clk,
	input wire logic                  i_rst_n,
	input wire logic                  o_master_reset_n,
	input wire logic                  o_shift_in,
	input wire logic                  o_shift_out,
	input wire logic [`WORD_BITS-1:0] o_data_in,
	input wire logic                  i_input_ready,
	input wire logic                  i_output_ready
);
//****
// Boot tracking
//****
logic booted;
logic next_booted;
default clocking @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
always_comb next_booted = booted | !o_master_reset_n;
always_ff @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) booted <= 1'b0;
	else booted <= next_booted;
end
// Timer loads 4 and acts at zero, so each pulse spans 5 cycles
sequence rst_pulse; !o_master_reset_n [*5] ##1 o_master_reset_n; endsequence
sequence si_pulse; o_shift_in [*5] ##1 !o_shift_in; endsequence
sequence so_pulse; o_shift_out [*5] ##1 !o_shift_out; endsequence
//****
// Properties
//****
a_rst_width: assert property ($fell(o_master_reset_n) |-> rst_pulse)
	else $error("reset pulse width wrong");
a_boot_first: assert property (
	$rose(o_shift_in | o_shift_out) |-> booted)
	else $error("strobe before first reset pulse");
a_rst_quiet: assert property (
	!o_master_reset_n |-> !(o_shift_in | o_shift_out))
	else $error("strobe during reset pulse");
a_si_width: assert property ($rose(o_shift_in) |-> si_pulse)
	else $error("shift-in width wrong");
a_so_width: assert property ($rose(o_shift_out) |-> so_pulse)
	else $error("shift-out width wrong");
a_si_data: assert property (o_shift_in |-> $stable(o_data_in))
	else $error("write word moved under strobe");
a_si_ready: assert property (
	$rose(o_shift_in) |-> $past(i_input_ready, 3))
	else $error("shift-in while not ready");
a_so_ready: assert property (
	$rose(o_shift_out) |-> $past(i_output_ready, 3))
	else $error("shift-out while not ready");
endmodule // fifo_ctl_chk
bind fifo_ctl fifo_ctl_chk fifo_ctl_chk_i (.i_clk, .i_rst_n, .o_master_reset_n,
	.o_shift_in, .o_shift_out, .o_data_in, .i_input_ready, .i_output_ready);
`default_nettype wire

// ===== fifo_dev_model.sv
/* Behavioural model of the 64 x 9 strobed fall-through buffer.
   Assumes strobes come from a controller; no delays are modelled. */
`timescale 1ns/100ps
`default_nettype none
`include "fifo_ctl_map.svh"
module fifo_dev_model (
	input  wire logic                  i_master_reset_n,
	input  wire logic                  i_shift_in,
	input  wire logic                  i_shift_out,
	input  wire logic                  i_output_enable_n,
	input  wire logic [`WORD_BITS-1:0] i_data_in,
	output logic      [`WORD_BITS-1:0] o_data_out,
	output logic                       o_input_ready,
	output logic                       o_output_ready,
	output logic                       o_occupancy_flag,
	output logic                       o_upper_half_flag
);
//****
// Storage and strobes
//****
logic [`WORD_BITS-1:0] mem [64];
logic [`WORD_BITS-1:0] latch_w, head;
logic                  took_in, took_out;
int                    wp, rp, cnt;
always @(negedge i_master_reset_n) begin
	{wp, rp, cnt, head, took_in, took_out} = '0;
	{o_input_ready, o_output_ready} = 2'b10;
	{o_occupancy_flag, o_upper_half_flag} = 2'b00;
end
always @(posedge i_shift_in)
	if (i_master_reset_n && cnt < 64) begin
	latch_w = i_data_in;
	took_in = 1'b1;
	o_input_ready = 1'b0;
	if (cnt == 32) o_upper_half_flag = 1'b1;
	if (cnt == 63) o_occupancy_flag = 1'b0;
end
always @(negedge i_shift_in) if (took_in) begin
	mem[wp] = latch_w;
	wp = (wp + 1) % 64;
	cnt++;
	took_in = 1'b0;
	if (cnt == 1) head = mem[rp];
	o_output_ready = 1'b1;
	o_occupancy_flag = (cnt < 64);
	o_input_ready = (cnt < 64);
end
always @(posedge i_shift_out)
	if (i_master_reset_n && cnt > 0) begin
	took_out = 1'b1;
	o_output_ready = 1'b0;
	if (cnt <= 32) o_upper_half_flag = 1'b0;
end
always @(negedge i_shift_out) if (took_out) begin
	rp = (rp + 1) % 64;
	cnt--;
	took_out = 1'b0;
	if (cnt > 0) head = mem[rp];
	o_output_ready = (cnt > 0);
	o_occupancy_flag = (cnt > 0);
	o_input_ready = !i_shift_in;
end
// A released bus shows the inverse so a stale sample never matches
assign o_data_out = i_output_enable_n ? ~head : head;
endmodule // fifo_dev_model
`default_nettype wire

// ===== tb_fifo_ctl.sv
/* Self-checking bench of the FIFO controller against the buffer model.
   Assumes the controller answers Avalon requests as its hand-over states. */
`timescale 1ns/100ps
`default_nettype none
`include "fifo_ctl_map.svh"
module tb_fifo_ctl;
logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wreq;
logic [3:0]  addr = 4'h0;
logic [31:0] wdata = 32'h0, rdata, st, r, seed = 32'h0000E243;
logic        mrn, si, so, oen, ir, ordy, occ, up, up_exp;
logic [8:0]  din, dout, q [$];
int          fail_count, checks, cyc, n;
fifo_ctl fifo_ctl_i (.i_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr),
	.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
	.o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
	.o_master_reset_n(mrn), .o_shift_in(si), .o_shift_out(so),
	.o_output_enable_n(oen), .o_data_in(din), .i_data_out(dout),
	.i_input_ready(ir), .i_output_ready(ordy), .i_occupancy_flag(occ),
	.i_upper_half_flag(up));
fifo_dev_model fifo_dev_model_i (.i_master_reset_n(mrn), .i_shift_in(si),
	.i_shift_out(so), .i_output_enable_n(oen), .i_data_in(din),
	.o_data_out(dout), .o_input_ready(ir), .o_output_ready(ordy),
	.o_occupancy_flag(occ), .o_upper_half_flag(up));
//****
// Helpers
//****
always #5 clk = ~clk;
function automatic logic [31:0] xs(input logic [31:0] s);
	s ^= s << 13;
	s ^= s >> 17;
	s ^= s << 5;
	return s;
endfunction
function automatic logic [31:0] exp_st(input int k, input logic u);
	logic o;
	o = (k > 0) && (k < 64);
	return {25'h0, u && !o, !u && !o, u, o, k > 0, k < 64, 1'b0};
endfunction
task check(input logic [31:0] seen, input logic [31:0] exp);
	checks++;
	if (seen !== exp) begin
		fail_count++;
		$display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
	end
endtask
task results;
	$display("checks %0d fail_count %0d", checks, fail_count);
	if (fail_count == 0 && checks > 0) $display("DONE - PASS");
	else $display("DONE - FAIL");
	$finish;
endtask
task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
	output logic [31:0] rv);
	@(posedge clk);
	addr <= a;
	wr <= w;
	rd <= !w;
	wdata <= d;
	do @(posedge clk); while (wreq !== 1'b0);
	rv = rdata;
	wr <= 1'b0;
	rd <= 1'b0;
endtask
// Busy is polled, never timed: the strobe timing is the designer's
task automatic idle;
	do bus(1'b0, `CTL_REG_STATUS, 32'h0, st); while (st[0] !== 1'b0);
endtask
task automatic op(input logic inw, input logic [8:0] d);
	logic rf;
	// A shift-in to a full buffer or a shift-out from an empty one is refused
	rf = inw ? (n >= 64) : (n == 0);
	if (inw) begin
		bus(1'b1, `CTL_REG_WDATA, {23'h0, d}, r);
		bus(1'b0, `CTL_REG_WDATA, 32'h0, r);
		check(r, {23'h0, d});
	end
	bus(1'b1, `CTL_REG_CMD, inw ? 32'hA : 32'hC, r);
	idle;
	if (inw && n < 64) begin
		if (n == 32) up_exp = 1'b1;
		n++;
		q.push_back(d);
	end
	if (!inw && n > 0) begin
		if (n <= 32) up_exp = 1'b0;
		n--;
		bus(1'b0, `CTL_REG_RDATA, 32'h0, r);
		check(r, {23'h0, q.pop_front()});
	end
	check(st & 32'hFE, exp_st(n, up_exp) | {24'h0, rf, 7'h0});
endtask
//****
// Sequence
//****
always @(posedge clk) begin
	cyc <= cyc + 1;
	if (cyc == 30000) begin
		fail_count++;
		results;
	end
end
initial begin
	{n, up_exp} = '0;
	repeat (3) @(posedge clk);
	rst_n <= 1'b1;
	idle;
	check(st, 32'h22);
	bus(1'b0, 4'h2, 32'h0, r);
	check(r, 32'h0);
	// Fill past full, drain past empty, then a random walk
	for (int i = 0; i < 400; i++) begin
		seed = xs(seed);
		op(i < 65 ? 1'b1 : i < 130 ? 1'b0 : seed[9], seed[8:0]);
	end
	bus(1'b1, `CTL_REG_CMD, 32'h9, r);
	idle;
	{n, up_exp} = '0;
	q.delete();
	check(st & 32'h7E, exp_st(0, 1'b0));
	op(1'b1, 9'h1A5);
	op(1'b0, 9'h0);
	results;
end
endmodule // tb_fifo_ctl
`default_nettype wire
